//--- logic/phs_pkg.sv
// Function
// - Ready contact closed while idle and accepting
// - Start opens ready, runs default recipe
// - Outputs updated before completion is signalled (outside local/remote: held values load on the edge that closes ready)
// - Ready closes at completion (local/remote: after results sent), then idle
// - Select contacts decode as binary recipe
// - Recipe taken from configurable assignment table
// - Under controller, start only from start input
// - Analog values load only at completion
// - Four outputs, each multiplexed to two channels
// - Forced test sequence steps analog outputs
// - Serial link 2400 baud, 8N1
// - Local/remote modes send results unprompted
// - Polled mode transmits only on request
// - Commands start, identity, results, status
// - Every transmission ends with code 26
package phs_pkg;
	localparam int DATA_W = 16;
	localparam int REC_W = 8;
	localparam int RSEL_W = 3;
	localparam int NCH = 8;
	localparam int NPHYS = 4;
	localparam int HEX_DIGITS = 4;
	localparam int CTRL_W = 5;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DONE = 8'h08;
	localparam logic [7:0] OFS_TABLE_LO = 8'h0c;
	localparam logic [7:0] OFS_TABLE_HI = 8'h10;
	localparam logic [7:0] OFS_DEFREC = 8'h14;
	localparam logic [7:0] OFS_RES0 = 8'h20;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RSEL_BIT = 2;
	localparam int CTRL_PLC_BIT = 3;
	localparam int CTRL_FORCE_BIT = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h08;
	localparam int STAT_READY = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_TXBUSY = 2;
	localparam int STAT_FORCE = 3;
	localparam int STAT_REC_LSB = 8;
	localparam int STAT_SEL_LSB = 16;
	localparam logic [2*32-1:0] TABLE_RESET = 64'h0706_0504_0302_0100;
	localparam logic [REC_W-1:0] DEFREC_RESET = 8'h00;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [DATA_W-1:0] ID_CODE = 16'h5a3c; // Arbitrary value
	localparam logic [DATA_W-1:0] FORCE_INC = 16'h1000;
	localparam logic [7:0] ASC_START = 8'h61;
	localparam logic [7:0] ASC_ID = 8'h69;
	localparam logic [7:0] ASC_RES = 8'h72;
	localparam logic [7:0] ASC_STAT = 8'h73;
	localparam logic [7:0] ASC_COMMA = 8'h2c;
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] ASC_NINE = 8'h39;
	localparam logic [7:0] ASC_HEXA = 8'h61;
	localparam logic [7:0] ASC_EOF = 8'h1a;
	localparam int UART_DATA_BITS = 8;
	localparam int UART_FRAME_BITS = 10;
	localparam int CLK_PERIOD_NS = 25;
	localparam int BAUD = 2400;
	localparam int BAUD_DIV = (1000000000 + BAUD * CLK_PERIOD_NS / 2) / (BAUD * CLK_PERIOD_NS);
	localparam int MUX_TIME_US = 100;
	localparam int MUX_CYC = MUX_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int FORCE_TIME_MS = 500;
	localparam int FORCE_CYC = FORCE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	typedef enum logic [1:0] {PHS_MODE_LOCAL, PHS_MODE_REMOTE, PHS_MODE_COMPUTER, PHS_MODE_SPARE}
		phs_mode_t;
	typedef enum logic [1:0] {PHS_MSG_RES, PHS_MSG_ID, PHS_MSG_STAT} phs_msg_t;
	function automatic logic [7:0] phs_hex(input logic [3:0] n);
		return (n < 4'ha) ? (ASC_ZERO + {4'h0, n}) : (ASC_HEXA + {4'h0, n} - 8'h0a);
	endfunction
endpackage

//--- logic/phs_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface phs_byte_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- logic/phs_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module phs_uart_tx #(
	parameter int DIV = phs_pkg::BAUD_DIV
)(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	phs_byte_if.snk s_in,
	output var logic o_txd
);
	import phs_pkg::*;
	localparam int CW = $clog2(DIV);
	typedef enum logic {TX_IDLE, TX_SHIFT} phs_tx_st_t;
	phs_tx_st_t st_q, st_d;
	logic [UART_DATA_BITS:0] sh_q, sh_d;
	logic [3:0] nbit_q, nbit_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic txd_q, txd_d;

	assign s_in.ready = (st_q == TX_IDLE);
	assign o_txd = txd_q;

	always_comb
	begin
		st_d = st_q;
		sh_d = sh_q;
		nbit_d = nbit_q;
		cnt_d = cnt_q;
		txd_d = txd_q;
		unique case (st_q)
			TX_IDLE:
				if (s_in.valid)
				begin
					sh_d = {1'b1, s_in.data};
					txd_d = 1'b0;
					nbit_d = 4'h0;
					cnt_d = '0;
					st_d = TX_SHIFT;
				end
			TX_SHIFT:
				if (cnt_q == CW'(DIV - 1))
				begin
					cnt_d = '0;
					if (nbit_q == 4'(UART_FRAME_BITS - 1))
						st_d = TX_IDLE;
					else
					begin
						txd_d = sh_q[0];
						sh_d = {1'b1, sh_q[UART_DATA_BITS:1]};
						nbit_d = nbit_q + 4'h1;
					end
				end
				else
					cnt_d = cnt_q + CW'(1);
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
		if (i_reset)
		begin
			st_q <= TX_IDLE;
			sh_q <= '1;
			nbit_q <= 4'h0;
			cnt_q <= '0;
			txd_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			sh_q <= sh_d;
			nbit_q <= nbit_d;
			cnt_q <= cnt_d;
			txd_q <= txd_d;
		end

	a_tx_start_bit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		st_q == TX_IDLE && s_in.valid |=> (!o_txd) [*8])
		else $error("Start bit not driven low");
endmodule
`default_nettype wire

//--- logic/phs_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module phs_uart_rx #(
	parameter int DIV = phs_pkg::BAUD_DIV
)(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_rxd,
	phs_byte_if.src s_out
);
	import phs_pkg::*;
	localparam int CW = $clog2(DIV);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} phs_rx_st_t;
	phs_rx_st_t st_q, st_d;
	logic [1:0] sync_q, sync_d;
	logic [UART_DATA_BITS-1:0] sh_q, sh_d, dat_q, dat_d;
	logic [2:0] nbit_q, nbit_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic vld_q, vld_d;
	logic rxd_s;

	assign rxd_s = sync_q[1];
	assign s_out.valid = vld_q;
	assign s_out.data = dat_q;

	always_comb
	begin
		sync_d = {sync_q[0], i_rxd};
		st_d = st_q;
		sh_d = sh_q;
		dat_d = dat_q;
		nbit_d = nbit_q;
		cnt_d = cnt_q + CW'(1);
		vld_d = vld_q && !s_out.ready;
		unique case (st_q)
			RX_IDLE:
			begin
				cnt_d = '0;
				if (!rxd_s)
					st_d = RX_START;
			end
			RX_START:
				if (cnt_q == CW'(DIV / 2 - 1))
				begin
					cnt_d = '0;
					nbit_d = 3'h0;
					st_d = rxd_s ? RX_IDLE : RX_DATA;
				end
			RX_DATA:
				if (cnt_q == CW'(DIV - 1))
				begin
					cnt_d = '0;
					sh_d = {rxd_s, sh_q[UART_DATA_BITS-1:1]};
					nbit_d = nbit_q + 3'h1;
					if (nbit_q == 3'(UART_DATA_BITS - 1))
						st_d = RX_STOP;
				end
			RX_STOP:
				if (cnt_q == CW'(DIV - 1))
				begin
					st_d = RX_IDLE;
					if (rxd_s)
					begin
						vld_d = 1'b1;
						dat_d = sh_q;
					end
				end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
		if (i_reset)
		begin
			sync_q <= 2'h3;
			st_q <= RX_IDLE;
			sh_q <= '0;
			dat_q <= '0;
			nbit_q <= 3'h0;
			cnt_q <= '0;
			vld_q <= 1'b0;
		end
		else
		begin
			sync_q <= sync_d;
			st_q <= st_d;
			sh_q <= sh_d;
			dat_q <= dat_d;
			nbit_q <= nbit_d;
			cnt_q <= cnt_d;
			vld_q <= vld_d;
		end

	a_rx_stop_bit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		$rose(vld_q) |-> $past(rxd_s) && $past(st_q) == RX_STOP)
		else $error("Byte delivered without stop bit");
endmodule
`default_nettype wire

//--- logic/phs_top.sv
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module phs_top #(
	parameter int BAUD_DIV = phs_pkg::BAUD_DIV,
	parameter int MUX_CYC = phs_pkg::MUX_CYC,
	parameter int FORCE_CYC = phs_pkg::FORCE_CYC
)(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output var logic o_hreadyout,
	output var logic o_hresp,
	output var logic [31:0] o_hrdata,
	input wire logic i_start_contact,
	input wire logic [phs_pkg::RSEL_W-1:0] i_rsel_contact,
	input wire logic i_rxd,
	output var logic o_txd,
	output var logic o_ready_closed,
	output var logic o_busy,
	output var logic [phs_pkg::REC_W-1:0] o_recipe,
	output var logic o_aout_bank,
	output var logic [phs_pkg::NPHYS*phs_pkg::DATA_W-1:0] o_aout_data
);
	import phs_pkg::*;
	localparam int MCW = $clog2(MUX_CYC);
	localparam int FCW = $clog2(FORCE_CYC);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_LAUNCH, ST_DRAIN} phs_state_t;
	typedef enum logic [1:0] {CP_IDLE, CP_COMMA, CP_TENS, CP_UNITS} phs_cp_t;

	phs_byte_if rx_bus ();
	phs_byte_if tx_bus ();
	logic [RSEL_W:0] sync1_q, sync2_q;
	logic start_prev_q, start_edge;
	logic accept, dp_wr_q, dp_wr_d, dp_rd_q, dp_rd_d, dp_map_q, dp_map_d;
	logic [7:0] dp_addr_q, dp_addr_d;
	logic hready_q, hready_d;
	logic [31:0] hrdata_q, hrdata_d, rd_word, stat_word;
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [2*32-1:0] table_q, table_d;
	logic [REC_W-1:0] defrec_q, defrec_d, recipe_q, recipe_d, table_pick, ser_recipe;
	logic [NCH-1:0][DATA_W-1:0] res_q, res_d, held_q, held_d;
	phs_state_t state_q, state_d;
	logic ready_q, ready_d, busy_q, busy_d;
	logic done_wr, launch, auto_mode, plc_en;
	phs_mode_t mode;
	phs_cp_t cp_q, cp_d;
	logic [3:0] tens_q, tens_d;
	logic is_digit, ser_start, host_req;
	phs_msg_t host_msg, msg_q, msg_d;
	logic seq_busy_q, seq_busy_d, tx_last;
	logic [3:0] ch_q, ch_d;
	logic [2:0] pos_q, pos_d;
	logic [1:0] nib;
	logic [7:0] tx_byte;
	logic [MCW-1:0] mux_cnt_q, mux_cnt_d;
	logic [FCW-1:0] frc_cnt_q, frc_cnt_d;
	logic [DATA_W-1:0] frc_val_q, frc_val_d;
	logic bank_q, bank_d, bank_out_q;
	logic [NPHYS*DATA_W-1:0] aout_q, aout_d;

	////////////////////////////////////////////////////////////////////////////////
	// Contact synchronisers and start edge
	always_ff @(posedge i_clk_sys or posedge i_reset)
		if (i_reset)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			start_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= {i_start_contact, i_rsel_contact};
			sync2_q <= sync1_q;
			start_prev_q <= sync2_q[RSEL_W];
		end

	assign start_edge = sync2_q[RSEL_W] && !start_prev_q;
	assign table_pick = table_q[REC_W * int'(sync2_q[RSEL_W-1:0]) +: REC_W];
	assign mode = phs_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign auto_mode = (mode == PHS_MODE_LOCAL) || (mode == PHS_MODE_REMOTE);
	assign plc_en = ctrl_q[CTRL_PLC_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave, registers and handshake sequence
	always_comb
	begin
		stat_word = '0;
		stat_word[STAT_READY] = ready_q;
		stat_word[STAT_BUSY] = busy_q;
		stat_word[STAT_TXBUSY] = seq_busy_q;
		stat_word[STAT_FORCE] = ctrl_q[CTRL_FORCE_BIT];
		stat_word[STAT_REC_LSB +: REC_W] = recipe_q;
		stat_word[STAT_SEL_LSB +: RSEL_W] = sync2_q[RSEL_W-1:0];
		rd_word = 32'h0;
		unique case (dp_addr_q)
			OFS_CTRL: rd_word = 32'(ctrl_q);
			OFS_STATUS: rd_word = stat_word;
			OFS_TABLE_LO: rd_word = table_q[31:0];
			OFS_TABLE_HI: rd_word = table_q[63:32];
			OFS_DEFREC: rd_word = 32'(defrec_q);
			default:
				for (int i = 0; i < NCH; i++)
					if (dp_addr_q == OFS_RES0 + 8'(4 * i))
						rd_word = 32'(res_q[i]);
		endcase
	end

	always_comb
	begin
		accept = i_hsel && i_htrans[1] && i_hready;
		dp_wr_d = accept && i_hwrite && (i_hsize == HSIZE_WORD);
		dp_rd_d = accept && !i_hwrite;
		dp_addr_d = accept ? i_haddr[7:0] : dp_addr_q;
		dp_map_d = accept ? (i_haddr[31:8] == 24'h0) : dp_map_q;
		hready_d = !dp_rd_d;
		hrdata_d = hrdata_q;
		if (dp_rd_q)
			hrdata_d = dp_map_q ? rd_word : 32'h0;
		ctrl_d = ctrl_q;
		table_d = table_q;
		defrec_d = defrec_q;
		res_d = res_q;
		done_wr = 1'b0;
		if (dp_wr_q && dp_map_q)
		begin
			unique case (dp_addr_q)
				OFS_CTRL: ctrl_d = i_hwdata[CTRL_W-1:0];
				OFS_DONE: done_wr = i_hwdata[0];
				OFS_TABLE_LO: table_d[31:0] = i_hwdata;
				OFS_TABLE_HI: table_d[63:32] = i_hwdata;
				OFS_DEFREC: defrec_d = i_hwdata[REC_W-1:0];
				default:
					for (int i = 0; i < NCH; i++)
						if (dp_addr_q == OFS_RES0 + 8'(4 * i))
							res_d[i] = i_hwdata[DATA_W-1:0];
			endcase
		end
		state_d = state_q;
		recipe_d = recipe_q;
		held_d = held_q;
		launch = 1'b0;
		unique case (state_q)
			ST_IDLE:
				if (plc_en ? start_edge : ser_start)
				begin
					state_d = ST_RUN;
					if (!plc_en)
						recipe_d = ser_recipe;
					else
						recipe_d = ctrl_q[CTRL_RSEL_BIT] ? table_pick : defrec_q;
				end
			ST_RUN:
				if (done_wr)
				begin
					held_d = res_q;
					state_d = auto_mode ? ST_LAUNCH : ST_IDLE;
				end
			ST_LAUNCH:
				if (!auto_mode)
					state_d = ST_IDLE;
				else if (!seq_busy_q)
				begin
					launch = 1'b1;
					state_d = ST_DRAIN;
				end
			ST_DRAIN:
				if (!seq_busy_q)
					state_d = ST_IDLE;
		endcase
		ready_d = (state_d == ST_IDLE);
		busy_d = (state_d == ST_RUN);
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
		if (i_reset)
		begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_map_q <= 1'b0;
			dp_addr_q <= 8'h00;
			hready_q <= 1'b1;
			hrdata_q <= 32'h0;
			ctrl_q <= CTRL_RESET;
			table_q <= TABLE_RESET;
			defrec_q <= DEFREC_RESET;
			res_q <= '0;
			held_q <= '0;
			state_q <= ST_IDLE;
			recipe_q <= DEFREC_RESET;
			ready_q <= 1'b1;
			busy_q <= 1'b0;
		end
		else
		begin
			dp_wr_q <= dp_wr_d;
			dp_rd_q <= dp_rd_d;
			dp_map_q <= dp_map_d;
			dp_addr_q <= dp_addr_d;
			hready_q <= hready_d;
			hrdata_q <= hrdata_d;
			ctrl_q <= ctrl_d;
			table_q <= table_d;
			defrec_q <= defrec_d;
			res_q <= res_d;
			held_q <= held_d;
			state_q <= state_d;
			recipe_q <= recipe_d;
			ready_q <= ready_d;
			busy_q <= busy_d;
		end

	assign o_hreadyout = hready_q;
	assign o_hresp = 1'b0;
	assign o_hrdata = hrdata_q;
	assign o_ready_closed = ready_q;
	assign o_busy = busy_q;
	assign o_recipe = recipe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Serial command parser and message sequencer
	assign rx_bus.ready = 1'b1;
	assign tx_bus.valid = seq_busy_q;
	assign tx_bus.data = tx_byte;
	assign is_digit = (rx_bus.data >= ASC_ZERO) && (rx_bus.data <= ASC_NINE);
	assign ser_recipe = REC_W'({4'h0, tens_q} * 8'd10 + {4'h0, rx_bus.data[3:0]});

	always_comb
	begin
		nib = 2'(HEX_DIGITS - 1) - pos_q[1:0];
		tx_last = 1'b0;
		tx_byte = ASC_EOF;
		unique case (msg_q)
			PHS_MSG_RES:
				if (ch_q == 4'(NCH))
					tx_last = 1'b1;
				else if (pos_q == 3'(HEX_DIGITS))
					tx_byte = ASC_COMMA;
				else
					tx_byte = phs_hex(held_q[ch_q[2:0]][{nib, 2'b00} +: 4]);
			PHS_MSG_ID:
				if (pos_q == 3'(HEX_DIGITS))
					tx_last = 1'b1;
				else
					tx_byte = phs_hex(ID_CODE[{nib, 2'b00} +: 4]);
			PHS_MSG_STAT:
				if (pos_q == 3'h2)
					tx_last = 1'b1;
				else
					tx_byte = phs_hex(stat_word[{~pos_q[0], 2'b00} +: 4]);
			default:
				tx_last = 1'b1;
		endcase
	end

	always_comb
	begin
		cp_d = cp_q;
		tens_d = tens_q;
		ser_start = 1'b0;
		host_req = 1'b0;
		host_msg = PHS_MSG_RES;
		if (rx_bus.valid)
		begin
			unique case (cp_q)
				CP_IDLE:
				begin
					cp_d = (rx_bus.data == ASC_START) ? CP_COMMA : CP_IDLE;
					host_req = 1'b1;
					if (rx_bus.data == ASC_ID)
						host_msg = PHS_MSG_ID;
					else if (rx_bus.data == ASC_STAT)
						host_msg = PHS_MSG_STAT;
					else if (rx_bus.data != ASC_RES)
						host_req = 1'b0;
				end
				CP_COMMA: cp_d = (rx_bus.data == ASC_COMMA) ? CP_TENS : CP_IDLE;
				CP_TENS:
				begin
					tens_d = rx_bus.data[3:0];
					cp_d = is_digit ? CP_UNITS : CP_IDLE;
				end
				CP_UNITS:
				begin
					cp_d = CP_IDLE;
					ser_start = is_digit;
				end
			endcase
		end
		seq_busy_d = seq_busy_q;
		msg_d = msg_q;
		ch_d = ch_q;
		pos_d = pos_q;
		if (!seq_busy_q)
		begin
			if (launch || host_req)
			begin
				seq_busy_d = 1'b1;
				msg_d = launch ? PHS_MSG_RES : host_msg;
				ch_d = 4'h0;
				pos_d = 3'h0;
			end
		end
		else if (tx_bus.ready)
		begin
			if (tx_last)
				seq_busy_d = 1'b0;
			else if (msg_q == PHS_MSG_RES && pos_q == 3'(HEX_DIGITS))
			begin
				pos_d = 3'h0;
				ch_d = ch_q + 4'h1;
			end
			else
				pos_d = pos_q + 3'h1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
		if (i_reset)
		begin
			cp_q <= CP_IDLE;
			tens_q <= 4'h0;
			seq_busy_q <= 1'b0;
			msg_q <= PHS_MSG_RES;
			ch_q <= 4'h0;
			pos_q <= 3'h0;
		end
		else
		begin
			cp_q <= cp_d;
			tens_q <= tens_d;
			seq_busy_q <= seq_busy_d;
			msg_q <= msg_d;
			ch_q <= ch_d;
			pos_q <= pos_d;
		end

	phs_uart_rx #(.DIV(BAUD_DIV)) u_rx (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_rxd(i_rxd),
		.s_out(rx_bus)
	);

	phs_uart_tx #(.DIV(BAUD_DIV)) u_tx (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.s_in(tx_bus),
		.o_txd(o_txd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Analog output multiplexing and forced test sequence
	always_comb
	begin
		mux_cnt_d = mux_cnt_q + MCW'(1);
		bank_d = bank_q;
		if (mux_cnt_q == MCW'(MUX_CYC - 1))
		begin
			mux_cnt_d = '0;
			bank_d = !bank_q;
		end
		frc_cnt_d = '0;
		frc_val_d = '0;
		if (ctrl_q[CTRL_FORCE_BIT])
		begin
			frc_cnt_d = frc_cnt_q + FCW'(1);
			frc_val_d = frc_val_q;
			if (frc_cnt_q == FCW'(FORCE_CYC - 1))
			begin
				frc_cnt_d = '0;
				frc_val_d = frc_val_q + FORCE_INC;
			end
		end
		for (int p = 0; p < NPHYS; p++)
			aout_d[p*DATA_W +: DATA_W] = ctrl_q[CTRL_FORCE_BIT] ? frc_val_q :
				held_q[NPHYS * int'(bank_q) + p];
	end

	always_ff @(posedge i_clk_sys or posedge i_reset)
		if (i_reset)
		begin
			mux_cnt_q <= '0;
			bank_q <= 1'b0;
			bank_out_q <= 1'b0;
			frc_cnt_q <= '0;
			frc_val_q <= '0;
			aout_q <= '0;
		end
		else
		begin
			mux_cnt_q <= mux_cnt_d;
			bank_q <= bank_d;
			bank_out_q <= bank_q;
			frc_cnt_q <= frc_cnt_d;
			frc_val_q <= frc_val_d;
			aout_q <= aout_d;
		end

	assign o_aout_bank = bank_out_q;
	assign o_aout_data = aout_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_ready_idle: assert property (o_ready_closed |-> state_q == ST_IDLE)
		else $error("Ready closed outside idle");
	a_start_opens: assert property (state_q == ST_IDLE && plc_en && start_edge
		|=> !o_ready_closed && o_busy && state_q == ST_RUN)
		else $error("Start did not open ready");
	a_plc_only_start: assert property (state_q == ST_IDLE && plc_en && !start_edge
		|=> state_q == ST_IDLE && o_ready_closed)
		else $error("Start without start contact");
	a_recipe_table: assert property (state_q == ST_IDLE && plc_en && start_edge
		&& ctrl_q[CTRL_RSEL_BIT] |=> o_recipe == $past(table_pick))
		else $error("Recipe not taken from table");
	a_held_stable: assert property (!(state_q == ST_RUN && done_wr) |=> $stable(held_q))
		else $error("Held values changed outside completion");
	a_ready_after_send: assert property (state_q == ST_DRAIN && !seq_busy_q
		|=> o_ready_closed ##1 o_ready_closed)
		else $error("Ready not closed after results sent");
	a_auto_send: assert property (state_q == ST_RUN && done_wr && auto_mode
		&& !seq_busy_q && !host_req |=> !o_ready_closed ##1 seq_busy_q && msg_q == PHS_MSG_RES)
		else $error("Results not sent unprompted");
	a_polled_only: assert property (mode == PHS_MODE_COMPUTER && !seq_busy_q
		&& !host_req |=> !seq_busy_q)
		else $error("Transmission without request");
	a_eof_last: assert property ($fell(seq_busy_q) |-> $past(tx_byte) == ASC_EOF)
		else $error("Message not ended with end-of-file");
endmodule
`default_nettype wire

//--- dv/phs_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module phs_plc_model #(
	parameter int DIV = 16
)(
	input wire logic i_clk_sys,
	input wire logic i_txd,
	input wire logic i_ready_closed,
	output var logic o_start_contact,
	output var logic [2:0] o_rsel_contact,
	output var logic o_rxd
);
	logic [7:0] rxq[$];
	logic [7:0] b;
	initial
	begin
		o_start_contact = 1'b0;
		o_rsel_contact = 3'h0;
		o_rxd = 1'b1;
	end
	////////////////////////////////
	// Select settles before start closes
	task automatic request(input logic [2:0] sel);
		o_rsel_contact <= sel;
		repeat (4) @(posedge i_clk_sys);
		o_start_contact <= i_ready_closed;
	endtask
	task automatic release_start;
		o_start_contact <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
	endtask
	// Lower-case command byte, 8N1, LSB first
	task automatic send(input logic [7:0] c);
		for (int i = 0; i < 10; i++)
		begin
			o_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
			repeat (DIV) @(posedge i_clk_sys);
		end
	endtask
	////////////////////////////////
	// Receiver samples mid bit
	always
	begin
		@(negedge i_txd);
		repeat (DIV / 2) @(posedge i_clk_sys);
		for (int i = 0; i < 8; i++)
		begin
			repeat (DIV) @(posedge i_clk_sys);
			b[i] = i_txd;
		end
		repeat (DIV) @(posedge i_clk_sys);
		rxq.push_back(b);
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import phs_pkg::*;
	localparam int DIV = 16;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic i_hsel = 1'b0;
	logic i_hwrite = 1'b0;
	logic [1:0] i_htrans = 2'h0;
	logic [31:0] i_haddr = 32'h0;
	logic [31:0] i_hwdata = 32'h0;
	logic hready, hresp, txd, rxd, start, ready, busy, bank;
	logic [2:0] rsel;
	logic [7:0] recipe, def;
	logic [31:0] hrdata, rd;
	logic [63:0] aout, tbl;
	logic [15:0] res[8];
	logic [15:0] held[8] = '{default: 16'h0};
	logic [31:0] ra[6] = '{OFS_CTRL, OFS_TABLE_LO, OFS_TABLE_HI, OFS_DEFREC, 32'h100, OFS_STATUS};
	logic [31:0] rv[6] = '{CTRL_RESET, TABLE_RESET[31:0], TABLE_RESET[63:32], DEFREC_RESET, 32'h0,
		32'h1};
	logic [7:0] cmd[4] = '{8'h61, 8'h2c, 8'h30, 8'h33};
	int error_cnt = 0;
	int n_checks = 0;
	always #12.5 i_clk_sys = ~i_clk_sys;
	phs_top #(.BAUD_DIV(DIV), .MUX_CYC(8), .FORCE_CYC(16)) dut (
		.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
		.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(HSIZE_WORD), .i_hwdata(i_hwdata),
		.i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_start_contact(start), .i_rsel_contact(rsel), .i_rxd(rxd), .o_txd(txd),
		.o_ready_closed(ready), .o_busy(busy), .o_recipe(recipe), .o_aout_bank(bank),
		.o_aout_data(aout));
	phs_plc_model #(.DIV(DIV)) m (
		.i_clk_sys(i_clk_sys), .i_txd(txd), .i_ready_closed(ready),
		.o_start_contact(start), .o_rsel_contact(rsel), .o_rxd(rxd));
	////////////////////////////////
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h57 + n;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Single word transfer, ready judged before each edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_haddr <= a;
		i_hwrite <= w;
		i_htrans <= 2'h2;
		do @(negedge i_clk_sys); while (hready !== 1'b1);
		@(posedge i_clk_sys);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(negedge i_clk_sys); while (hready !== 1'b1);
		rd = hrdata;
		@(posedge i_clk_sys);
	endtask
	task automatic wt(input logic sel, input logic val);
		int k;
		k = 0;
		do
		begin
			@(negedge i_clk_sys);
			k++;
		end
		while ((sel ? ready : busy) !== val && k < 20000);
		if (k >= 20000)
			error_cnt++;
		@(posedge i_clk_sys);
	endtask
	task automatic getn(input int n);
		for (int k = 0; k < 20000 && m.rxq.size() < n; k++)
			@(posedge i_clk_sys);
		if (m.rxq.size() < n)
			error_cnt++;
	endtask
	task automatic chk_aout;
		for (int j = 0; j < 12; j++)
		begin
			@(negedge i_clk_sys);
			for (int p = 0; p < 4; p++)
				chk(aout[16*p+:16], held[p+4*bank]);
		end
		@(posedge i_clk_sys);
	endtask
	// One contact-driven analysis
	task automatic run(input logic [2:0] sel, input logic [7:0] rec);
		m.request(sel);
		wt(1'b0, 1'b1);
		chk({busy, ready, recipe}, {2'b10, rec});
		foreach (res[i])
		begin
			res[i] = 16'($urandom);
			bus(1'b1, OFS_RES0 + 4 * i, {16'h0, res[i]});
		end
		chk_aout;
		bus(1'b1, OFS_DONE, 32'h1);
		wt(1'b1, 1'b1);
		chk(busy, 1'b0);
		held = res;
		chk_aout;
		chk({busy, ready}, 2'b01);
		m.release_start;
		$display("test run select %0d done", sel);
	endtask
	////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge i_clk_sys);
		error_cnt++;
		finish_test();
	end
	initial
	begin
		void'($urandom(24324));
		repeat (6) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		@(posedge i_clk_sys);
		chk(ready, 1'b1);
		foreach (ra[i])
		begin
			bus(1'b0, ra[i], 32'h0);
			chk({hresp, rd}, {1'b0, rv[i]});
		end
		$display("test reset values done");
		tbl = {$urandom, $urandom};
		def = 8'($urandom);
		bus(1'b1, OFS_TABLE_LO, tbl[31:0]);
		bus(1'b1, OFS_TABLE_HI, tbl[63:32]);
		bus(1'b1, OFS_DEFREC, {24'h0, def});
		for (int k = 0; k < 9; k++)
		begin
			bus(1'b1, OFS_CTRL, (k < 8) ? 32'h0e | 32'(k & 1) : 32'h0a);
			run(3'(k), (k < 8) ? tbl[8*k+:8] : def);
		end
		chk(m.rxq.size(), 0);
		m.rxq.delete();
		bus(1'b1, OFS_CTRL, 32'h08 | ($urandom & 32'h1));
		run(3'($urandom), def);
		getn(41);
		chk(m.rxq.size(), 41);
		chk({m.rxq[0], m.rxq[4], m.rxq[40]}, {hx(res[0][15:12]), 8'h2c, 8'h1a});
		m.rxq.delete();
		bus(1'b1, OFS_CTRL, 32'h02);
		foreach (cmd[i])
			m.send(cmd[i]);
		wt(1'b0, 1'b1);
		chk(recipe, 8'h03);
		bus(1'b1, OFS_DONE, 32'h1);
		wt(1'b1, 1'b1);
		repeat (300) @(posedge i_clk_sys);
		chk(m.rxq.size(), 0);
		m.send(8'h69);
		getn(5);
		for (int i = 0; i < 4; i++)
			chk(m.rxq[i], hx(ID_CODE[15-4*i-:4]));
		m.send(8'h73);
		getn(8);
		m.send(8'h72);
		getn(49);
		chk({m.rxq[4], m.rxq[7], m.rxq[8], m.rxq[48]}, {8'h1a, 8'h1a, hx(held[0][15:12]), 8'h1a});
		bus(1'b1, OFS_CTRL, 32'h0a);
		foreach (cmd[i])
			m.send(cmd[i]);
		repeat (20) @(posedge i_clk_sys);
		chk(busy, 1'b0);
		$display("test serial done");
		bus(1'b1, OFS_CTRL, 32'h1a);
		repeat (3) @(negedge i_clk_sys);
		chk(aout, 64'h0);
		repeat (16) @(negedge i_clk_sys);
		chk(aout, {4{FORCE_INC}});
		@(posedge i_clk_sys);
		bus(1'b1, OFS_CTRL, 32'h0a);
		repeat (3) @(posedge i_clk_sys);
		chk_aout;
		$display("test force done");
		finish_test();
	end
endmodule
`default_nettype wire
